/* src/ifb_fetcher.sv */
// Functional notes
// - First opcode byte: zero-extended, opcode map enabled
// - First opcode byte low four bits captured
// - Positive operand byte zero-extended on bus
// - Negative operand byte ones-extended on bus
// - Branch operand byte: no refill after last
// - Refill on last byte and on offset or base load
// - Base and offset load from bus
// - Base and offset readable onto bus
// - Address is base shifted two plus offset
// - Block fetched as one eight-byte read
// - Low three bits select one held byte
// - Code frames start on four-byte boundaries
// - Fetch address space limited to 256K bytes
// - Offset increments on every byte taken
// - Offset counter wraps from 32767 to 0
`timescale 1ns/1ns
`default_nettype none
module ifb_fetcher
  import ifb_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Bus strobes from the control unit
  input wire logic first_opcode_byte_strobe,
  input wire logic positive_operand_byte_strobe,
  input wire logic negative_operand_byte_strobe,
  input wire logic branch_operand_byte_strobe,
  input wire logic load_byte_offset_strobe,
  input wire logic read_byte_offset_strobe,
  input wire logic load_frame_base_strobe,
  input wire logic read_frame_base_strobe,
  // Processor bus
  input wire logic [IFB_BUS_W-1:0] bus_in,
  output logic [IFB_BUS_W-1:0] bus_out,
  output logic bus_oe_n,
  // Control unit side
  output logic opcode_map_enable,
  output logic [3:0] small_const,
  output logic byte_stall,
  // Memory fetch request
  output logic fetch_req,
  output logic [IFB_ADDR_W-1:0] fetch_addr,
  input wire logic fetch_data_valid,
  input wire logic [IFB_BLOCK_W-1:0] fetch_data
);

  ////////////////////////////////////////////////////////////////////////////
  logic [IFB_FRAME_W-1:0] frame_r;
  logic [IFB_OFFSET_W-1:0] offset_r;
  logic [7:0] hold_r [IFB_BLOCK_BYTES];
  logic block_valid_r;
  logic need_r;
  logic pending_r;
  logic stale_r;
  logic [IFB_ADDR_W-1:0] fetch_addr_r;
  logic [IFB_BUS_W-1:0] bus_out_r;
  logic bus_oe_n_r;
  logic opcode_map_enable_r;
  logic [3:0] small_const_r;

  logic [IFB_ADDR_W-1:0] eff_addr;
  logic [IFB_SEL_W-1:0] sel;
  logic [7:0] cur_byte;
  logic byte_req;
  logic take;
  logic last_take;
  logic redirect;
  logic launch;

  // Base carries two zero bits below it, so frames sit on 4-byte bounds
  assign eff_addr = {frame_r, {IFB_FRAME_SHIFT{1'b0}}} + {3'b000, offset_r};
  assign sel = eff_addr[IFB_SEL_W-1:0];
  assign cur_byte = hold_r[sel];
  assign byte_req = first_opcode_byte_strobe | positive_operand_byte_strobe |
                    negative_operand_byte_strobe | branch_operand_byte_strobe;
  assign take = byte_req & block_valid_r & ~redirect;
  assign byte_stall = byte_req & ~block_valid_r;
  assign last_take = take & (sel == IFB_LAST_SEL);
  assign redirect = load_byte_offset_strobe | load_frame_base_strobe;
  // A request leaves only when none is in flight and no reload lands with it
  assign launch = need_r & ~pending_r & ~redirect;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      frame_r <= IFB_FRAME_RST;
    end else if (load_frame_base_strobe) begin
      frame_r <= bus_in[IFB_FRAME_W-1:0];
    end
  end

  // 15-bit counter: code frames cannot exceed 32768 bytes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      offset_r <= IFB_OFFSET_RST;
    end else if (load_byte_offset_strobe) begin
      offset_r <= bus_in[IFB_OFFSET_W-1:0];
    end else if (take) begin
      offset_r <= offset_r + IFB_OFFSET_STEP;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // No check whether a branch target stays inside the held block
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      block_valid_r <= 1'b0;
    end else if (redirect || last_take) begin
      block_valid_r <= 1'b0;
    end else if (pending_r && fetch_data_valid && !stale_r) begin
      block_valid_r <= 1'b1;
    end
  end

  // Set while a block is wanted and its request has not gone out yet
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      need_r <= 1'b0;
    end else if (redirect) begin
      need_r <= 1'b1;
    end else if (last_take && !branch_operand_byte_strobe) begin
      need_r <= 1'b1;
    end else if (pending_r && fetch_data_valid && stale_r) begin
      need_r <= 1'b1;
    end else if (launch) begin
      // Cleared as the request leaves, so one need gives exactly one fetch
      need_r <= 1'b0;
    end else if (byte_stall && !pending_r) begin
      // Catches a request after a branch-strobe skip that saw no reload
      need_r <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pending_r <= 1'b0;
    end else if (pending_r && fetch_data_valid) begin
      // Request level ends with the data-valid cycle
      pending_r <= 1'b0;
    end else if (launch) begin
      pending_r <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fetch_addr_r <= '0;
    end else if (launch) begin
      // Memory reads from the exact address given, so the low three bits go out as zero to start the block on an 8-byte bound
      fetch_addr_r <= {eff_addr[IFB_ADDR_W-1:IFB_SEL_W], {IFB_SEL_W{1'b0}}};
    end
  end

  // A reload during a refill makes the arriving block useless
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stale_r <= 1'b0;
    end else if (redirect && (pending_r || need_r)) begin
      // A block arriving in the reload cycle is already dropped by the reload
      stale_r <= pending_r && !fetch_data_valid;
    end else if (pending_r && fetch_data_valid) begin
      stale_r <= 1'b0;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < IFB_BLOCK_BYTES; gi++) begin : g_hold
      // Byte 0 of a block sits in the lowest bits of the memory word
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          hold_r[gi] <= 8'h00;
        end else if (pending_r && fetch_data_valid && !stale_r) begin
          hold_r[gi] <= fetch_data[8*gi +: 8];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bus_out_r <= '0;
      bus_oe_n_r <= 1'b1;
    end else begin
      bus_oe_n_r <= ~(take | read_byte_offset_strobe | read_frame_base_strobe);
      if (take && negative_operand_byte_strobe) begin
        bus_out_r <= {IFB_EXT_NEG, cur_byte};
      end else if (take) begin
        bus_out_r <= {IFB_EXT_POS, cur_byte};
      end else if (read_frame_base_strobe) begin
        bus_out_r <= frame_r;
      end else if (read_byte_offset_strobe) begin
        bus_out_r <= {1'b0, offset_r};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      opcode_map_enable_r <= 1'b0;
      small_const_r <= 4'h0;
    end else begin
      opcode_map_enable_r <= take & first_opcode_byte_strobe;
      if (take && first_opcode_byte_strobe) begin
        small_const_r <= cur_byte[3:0];
      end
    end
  end

  assign bus_out = bus_out_r;
  assign bus_oe_n = bus_oe_n_r;
  assign opcode_map_enable = opcode_map_enable_r;
  assign small_const = small_const_r;
  assign fetch_req = pending_r;
  assign fetch_addr = fetch_addr_r;

endmodule : ifb_fetcher
`default_nettype wire

/* src/ifb_pkg.sv */
package ifb_pkg;
  localparam int IFB_BUS_W = 16;
  localparam int IFB_FRAME_W = 16;
  localparam int IFB_OFFSET_W = 15;
  localparam int IFB_ADDR_W = 18;
  localparam int IFB_FRAME_SHIFT = 2;
  localparam int IFB_BLOCK_BYTES = 8;
  localparam int IFB_SEL_W = 3;
  localparam int IFB_BLOCK_W = 64;
  localparam logic [IFB_FRAME_W-1:0] IFB_FRAME_RST = 16'h0000;
  localparam logic [IFB_OFFSET_W-1:0] IFB_OFFSET_RST = 15'h0000;
  localparam logic [IFB_OFFSET_W-1:0] IFB_OFFSET_STEP = 15'h0001;
  localparam logic [IFB_SEL_W-1:0] IFB_LAST_SEL = 3'h7;
  localparam logic [7:0] IFB_EXT_POS = 8'h00;
  localparam logic [7:0] IFB_EXT_NEG = 8'hff;
endpackage : ifb_pkg

/* sim/ifb_mem_model.sv */
`timescale 1ns/1ns
`default_nettype none
module ifb_mem_model
  import ifb_pkg::*;
#(parameter int DLY = 3)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic fetch_req,
  input wire logic [IFB_ADDR_W-1:0] fetch_addr,
  output logic fetch_data_valid,
  output logic [IFB_BLOCK_W-1:0] fetch_data
);
  logic [3:0] cnt_r;
  logic [IFB_BLOCK_W-1:0] blk;
  always_comb begin
    logic [17:0] a;
    a = 18'h00000;
    for (int i = 0; i < 8; i++) begin
      a = fetch_addr + 18'(i);
      blk[8*i+:8] = a[7:0] ^ a[17:10];
    end
  end
  // Inverted outside the valid cycle so a late sample shows up
  assign fetch_data = fetch_data_valid ? blk : ~blk;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_r <= 4'h0;
      fetch_data_valid <= 1'b0;
    end else begin
      fetch_data_valid <= fetch_req && !fetch_data_valid && cnt_r == 4'(DLY);
      cnt_r <= (fetch_req && !fetch_data_valid && cnt_r != 4'(DLY)) ? cnt_r + 4'h1 : 4'h0;
    end
  end
endmodule : ifb_mem_model
`default_nettype wire

/* sim/ifb_fetcher_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module ifb_fetcher_sva (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Byte and load strobes
  input wire logic first_opcode_byte_strobe,
  input wire logic positive_operand_byte_strobe,
  input wire logic negative_operand_byte_strobe,
  input wire logic branch_operand_byte_strobe,
  input wire logic load_byte_offset_strobe,
  input wire logic load_frame_base_strobe,
  // Bus and control outputs
  input wire logic [15:0] bus_out,
  input wire logic bus_oe_n,
  input wire logic opcode_map_enable,
  input wire logic [3:0] small_const,
  input wire logic byte_stall,
  // Memory request
  input wire logic fetch_req,
  input wire logic [17:0] fetch_addr,
  input wire logic fetch_data_valid
);
  wire logic tk = (first_opcode_byte_strobe | positive_operand_byte_strobe |
    negative_operand_byte_strobe | branch_operand_byte_strobe) & !byte_stall &
    !load_byte_offset_strobe & !load_frame_base_strobe;
  wire logic fs = tk & first_opcode_byte_strobe;
  wire logic ng = tk & negative_operand_byte_strobe;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_byte_drive: assert property (tk |=> !bus_oe_n) else $error("byte not driven");
  a_neg_ext: assert property (ng |=> bus_out[15:8] == 8'hff) else $error("bad ones");
  a_pos_ext: assert property (tk && !ng |=> bus_out[15:8] == 8'h00) else $error("bad ext");
  a_map_pulse: assert property (fs |=> opcode_map_enable) else $error("no map");
  a_small_const: assert property (fs |=> small_const == bus_out[3:0]) else $error("nib");
  a_block_align: assert property (fetch_req |-> fetch_addr[2:0] == 3'h0) else $error("al");
  a_req_hold:
    assert property (fetch_req && !fetch_data_valid |=> fetch_req && $stable(fetch_addr))
    else $error("request dropped");
  a_load_refill:
    assert property (load_byte_offset_strobe |-> ##[1:3] fetch_req) else $error("no refill");
  c_neg: cover property (ng);
  c_fill: cover property (fetch_data_valid);
  c_stall: cover property (byte_stall);
endmodule : ifb_fetcher_sva
`default_nettype wire

/* sim/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import ifb_pkg::*;
  logic sys_clk = 0, rst = 1, bus_oe_n, opcode_map_enable, byte_stall, fetch_req, fetch_data_valid;
  logic [3:0] s = 0, small_const;
  logic [1:0] l = 0, r = 0;
  logic [15:0] bus_in = 0, bus_out;
  logic [17:0] fetch_addr, e;
  logic [63:0] fetch_data;
  int miscompares = 0, n_checks = 0, cyc = 0;
  initial forever #4 sys_clk = ~sys_clk;
  ifb_fetcher dut (.sys_clk, .rst, .first_opcode_byte_strobe(s[0]),
    .positive_operand_byte_strobe(s[1]), .negative_operand_byte_strobe(s[2]),
    .branch_operand_byte_strobe(s[3]), .load_byte_offset_strobe(l[0]),
    .load_frame_base_strobe(l[1]), .read_byte_offset_strobe(r[0]), .read_frame_base_strobe(r[1]),
    .bus_in, .bus_out, .bus_oe_n, .opcode_map_enable, .small_const, .byte_stall, .fetch_req,
    .fetch_addr, .fetch_data_valid, .fetch_data);
  ifb_mem_model mem (.sys_clk, .rst, .fetch_req, .fetch_addr, .fetch_data_valid, .fetch_data);
  task automatic chk(string n, logic [15:0] x, logic [15:0] v);
    n_checks++;
    if (v !== x) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, x, v);
    end
  endtask : chk
  task automatic take(int k);
    logic [7:0] b;
    b = e[7:0] ^ e[17:10];
    @(posedge sys_clk) s[k] <= 1'b1;
    // Strobe is held while the block is missing
    repeat (40) begin
      @(negedge sys_clk);
      if (byte_stall === 1'b0) break;
    end
    @(posedge sys_clk) s <= 4'h0;
    @(negedge sys_clk);
    chk("byte", {k == 2 ? 8'hff : 8'h00, b}, bus_out);
    chk("oe_n", 16'h0, {15'h0, bus_oe_n});
    if (k == 0) chk("map", 16'h1, {15'h0, opcode_map_enable});
    if (k == 0) chk("nib", {12'h0, b[3:0]}, {12'h0, small_const});
    e = e + 18'h1;
  endtask : take
  task automatic wr(int i, logic [15:0] v);
    @(posedge sys_clk) begin
      l[i] <= 1'b1;
      bus_in <= v;
    end
    @(posedge sys_clk) l <= 2'h0;
  endtask : wr
  task automatic rd(int i, logic [15:0] x);
    @(posedge sys_clk) r[i] <= 1'b1;
    @(posedge sys_clk) r <= 2'h0;
    @(negedge sys_clk) chk("reg", x, bus_out);
  endtask : rd
  task automatic run_stream;
    wr(1, 16'h4001);
    wr(0, 16'h0005);
    e = 18'h10009;
    for (int k = 0; k < 11; k++) take(k % 4);
  endtask : run_stream
  task automatic run_branch;
    wr(0, 16'h0003);
    e = 18'h10007;
    take(3);
    repeat (4) @(negedge sys_clk) chk("req", 16'h0, {15'h0, fetch_req});
    rd(0, 16'h0004);
    rd(1, 16'h4001);
    take(1);
  endtask : run_branch
  task automatic run_wrap;
    wr(0, 16'h7fff);
    e = 18'h18003;
    take(0);
    rd(0, 16'h0000);
  endtask : run_wrap
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      summarize;
    end
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    run_stream;
    run_branch;
    run_wrap;
    summarize;
  end
endmodule : testbench
bind ifb_fetcher ifb_fetcher_sva sva (
  .sys_clk(sys_clk),
  .rst(rst),
  .first_opcode_byte_strobe(first_opcode_byte_strobe),
  .positive_operand_byte_strobe(positive_operand_byte_strobe),
  .negative_operand_byte_strobe(negative_operand_byte_strobe),
  .branch_operand_byte_strobe(branch_operand_byte_strobe),
  .load_byte_offset_strobe(load_byte_offset_strobe),
  .load_frame_base_strobe(load_frame_base_strobe),
  .bus_out(bus_out),
  .bus_oe_n(bus_oe_n),
  .opcode_map_enable(opcode_map_enable),
  .small_const(small_const),
  .byte_stall(byte_stall),
  .fetch_req(fetch_req),
  .fetch_addr(fetch_addr),
  .fetch_data_valid(fetch_data_valid)
);
`default_nettype wire
